// [core/sarc_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
module sarc_ctrl (
  input wire logic core_clk_i,              // core clock, 200 MHz
  input wire logic rst_n_i,                 // async reset, active low
  input wire logic instr_tick_i,            // one pulse per machine cycle
  input wire logic osc_clk_i,               // on-chip oscillator level, async
  input wire logic comp_above_i,            // analog comparator: reference below input
  input wire logic [3:0] acc_i,             // accumulator A
  input wire logic [3:0] b_i,               // register B
  input wire logic write_mode_select_op_i,  // A to mode/input register
  input wire logic read_mode_select_op_i,   // mode/input register to A
  input wire logic write_pin_func_op_i,     // A to pin function register
  input wire logic read_pin_func_op_i,      // pin function register to A
  input wire logic write_clk_sel_op_i,      // A to clock select register
  input wire logic read_clk_sel_op_i,       // clock select register to A
  input wire logic convert_start_op_i,      // start conversion or comparison
  input wire logic read_result_high_op_i,   // result bits 9:2 to B:A
  input wire logic read_result_low_op_i,    // result bits 1:0 to A bits 3:2
  input wire logic load_threshold_op_i,     // B:A to threshold
  input wire logic read_threshold_op_i,     // threshold to B:A
  input wire logic done_flag_skip_test_i,   // skip test of the done flag
  input wire logic int_accept_i,            // converter interrupt accepted
  input wire logic int_route_sel_i,         // interrupt control two: 1 interrupt, 0 skip
  output logic [3:0] acc_o,                 // value returned to A
  output logic [3:0] b_o,                   // value returned to B
  output logic skip_o,                      // skip next instruction
  output logic irq_req_o,                   // converter interrupt request
  output logic conversion_done_flag_o,      // completion / comparison flag
  output logic busy_o,                      // operation running
  output logic [9:0] dac_code_o,            // internal DAC code
  output logic [1:0] analog_sel_o,          // selected analog input
  output logic analog_sel_valid_o,          // select code is available
  output logic [3:0] analog_pin_en_o        // pins in analog function
);
  import sarc_pkg::*;

  logic [3:0] converter_mode_input_select;
  logic [3:0] analog_pin_function_select;
  logic [3:0] converter_clock_select;
  logic [9:0] successive_result;
  logic [7:0] comparator_threshold;
  logic conversion_done_flag;
  sarc_state_e state;
  sarc_state_e next_state;
  logic [9:0] next_result;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic [1:0] mc_cnt;
  logic [1:0] next_mc_cnt;
  logic done_set;
  logic div_restart;
  logic comp_mode;
  logic comp_sync;
  logic osc_sync;
  logic osc_prev;
  logic osc_tick;
  logic src_tick;
  logic converter_clock_tick;
  logic route_int;
  logic skip_hit;
  logic flag_clear;

  assign comp_mode = converter_mode_input_select[MODE_BIT];
  assign route_int = int_route_sel_i;

  sarc_sync u_comp_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(comp_above_i),
    .sync_o(comp_sync)
  );

  sarc_sync u_osc_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(osc_clk_i),
    .sync_o(osc_sync)
  );

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      osc_prev <= 1'b0;
    else
      osc_prev <= osc_sync;
  end

  assign osc_tick = osc_sync && !osc_prev;
  // oscillator must run well below half the core clock to be counted
  assign src_tick = converter_clock_select[CLK_SRC_BIT] ? osc_tick : instr_tick_i;

  sarc_clk_div u_clk_div (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(src_tick),
    .ratio_i(sarc_div_ratio(converter_clock_select[1:0])),
    .restart_i(div_restart),
    .converter_clock_tick_o(converter_clock_tick)
  );

  // control registers: reset is the only clear, so RAM back-up keeps them
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      converter_mode_input_select <= CTRL_RESET;
    else if (write_mode_select_op_i)
      converter_mode_input_select <= acc_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      analog_pin_function_select <= CTRL_RESET;
    else if (write_pin_func_op_i)
      analog_pin_function_select <= acc_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      converter_clock_select <= CTRL_RESET;
    else if (write_clk_sel_op_i)
      converter_clock_select <= acc_i;
  end

  // threshold is a separate store, untouched by conversions and mode changes
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      comparator_threshold <= THR_RESET;
    else if (load_threshold_op_i && comp_mode)
      comparator_threshold <= {b_i, acc_i};
  end

  always_comb
  begin
    next_state = state;
    next_result = successive_result;
    next_bit_idx = bit_idx;
    next_mc_cnt = mc_cnt;
    done_set = 1'b0;
    div_restart = 1'b0;
    case (state)
      SARC_IDLE:
      begin
        if (convert_start_op_i)
        begin
          next_state = SARC_WAIT;
          next_mc_cnt = 2'h0;
          if (!comp_mode)
            next_result = RESULT_CLEAR;
        end
      end
      SARC_WAIT:
      begin
        if (instr_tick_i)
        begin
          next_mc_cnt = 2'(mc_cnt + 2'h1);
          if (mc_cnt == MC_WAIT_LAST)
          begin
            div_restart = 1'b1;
            if (comp_mode)
              next_state = SARC_CMP;
            else
            begin
              next_state = SARC_SAR;
              next_bit_idx = SAR_TOP_BIT;
              next_result[SAR_TOP_BIT] = 1'b1;
            end
          end
        end
      end
      SARC_SAR:
      begin
        if (converter_clock_tick)
        begin
          next_result[bit_idx] = comp_sync;
          if (bit_idx == SAR_LAST_BIT)
          begin
            next_state = SARC_IDLE;
            done_set = 1'b1;
          end
          else
          begin
            next_bit_idx = 4'(bit_idx - 4'h1);
            next_result[4'(bit_idx - 4'h1)] = 1'b1;
          end
        end
      end
      SARC_CMP:
      begin
        if (converter_clock_tick)
        begin
          next_state = SARC_IDLE;
          done_set = !comp_sync;
        end
      end
      default:
        next_state = SARC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state <= SARC_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_idx <= SAR_TOP_BIT;
      mc_cnt <= 2'h0;
    end
    else
    begin
      bit_idx <= next_bit_idx;
      mc_cnt <= next_mc_cnt;
    end
  end

  // written only by the sequence; comparator mode leaves stale contents
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      successive_result <= RESULT_CLEAR;
    else
      successive_result <= next_result;
  end

  // set wins over a same-cycle clear so a finish is never lost
  assign skip_hit = done_flag_skip_test_i && !route_int && conversion_done_flag;
  assign flag_clear = (int_accept_i && route_int) || skip_hit;

  // a mode write is not blocked; a flag set then is left for software
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      conversion_done_flag <= 1'b0;
    else if (done_set)
      conversion_done_flag <= 1'b1;
    else if (flag_clear)
      conversion_done_flag <= 1'b0;
  end

  assign conversion_done_flag_o = conversion_done_flag;
  assign irq_req_o = conversion_done_flag && route_int;
  assign skip_o = skip_hit;
  assign busy_o = (state != SARC_IDLE);

  // 8-bit threshold sits in the top bits so one LSB is a 1/256 step
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dac_code_o <= RESULT_CLEAR;
    else if (comp_mode)
      dac_code_o <= {comparator_threshold, 2'h0};
    else
      dac_code_o <= next_result;
  end

  // reads are not interlocked with a running conversion
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_o <= 4'h0;
      b_o <= 4'h0;
    end
    else if (read_result_high_op_i)
    begin
      b_o <= successive_result[9:6];
      acc_o <= successive_result[5:2];
    end
    else if (read_result_low_op_i)
      acc_o <= {successive_result[1:0], 2'h0};
    else if (read_threshold_op_i && comp_mode)
    begin
      b_o <= comparator_threshold[7:4];
      acc_o <= comparator_threshold[3:0];
    end
    else if (read_mode_select_op_i)
      acc_o <= converter_mode_input_select;
    else if (read_pin_func_op_i)
      acc_o <= analog_pin_function_select;
    else if (read_clk_sel_op_i)
      acc_o <= converter_clock_select;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      analog_sel_o <= 2'h0;
      analog_sel_valid_o <= 1'b1;
      analog_pin_en_o <= 4'h0;
    end
    else
    begin
      analog_sel_o <= converter_mode_input_select[1:0];
      analog_sel_valid_o <= (converter_mode_input_select[2:0] <= SEL_MAX_VALID);
      analog_pin_en_o <= {analog_pin_function_select[PIN_PAIR_BIT],
                          analog_pin_function_select[PIN_PAIR_BIT],
                          analog_pin_function_select[1:0]};
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_conv_start;
    state == SARC_IDLE && convert_start_op_i && !comp_mode;
  endsequence

  sequence s_wait_over;
    state == SARC_WAIT && instr_tick_i && mc_cnt == MC_WAIT_LAST;
  endsequence

  sequence s_last_compare;
    state == SARC_SAR && converter_clock_tick && bit_idx == SAR_LAST_BIT;
  endsequence

  a_start_clears_result: assert property (s_conv_start |=> successive_result == 10'h000)
    else $error("result not cleared at start");
  a_wait_two_cycles: assert property (s_wait_over
    |=> state == SARC_SAR || state == SARC_CMP)
    else $error("sequence did not leave wait after two machine cycles");
  a_wait_holds: assert property ((state == SARC_WAIT && !instr_tick_i)
    |=> state == SARC_WAIT)
    else $error("wait left without a machine cycle");
  a_last_sets_flag: assert property (s_last_compare
    |=> state == SARC_IDLE && conversion_done_flag)
    else $error("tenth compare did not finish the conversion");
  a_trial_bit_set: assert property (
    (state == SARC_SAR && converter_clock_tick && bit_idx != SAR_LAST_BIT)
    |=> successive_result[bit_idx] == 1'b1 && bit_idx == $past(bit_idx) - 4'h1)
    else $error("next trial bit not set");
  a_cmp_one_clock: assert property ((state == SARC_CMP && converter_clock_tick)
    |=> state == SARC_IDLE && (conversion_done_flag || $past(comp_sync)))
    else $error("comparison did not end on one converter clock");
  a_skip_clears: assert property ((skip_hit && !done_set) |=> !conversion_done_flag)
    else $error("skip test did not clear the flag");
  a_set_wins: assert property (done_set |=> conversion_done_flag)
    else $error("finish lost against a clear");
  a_low_read: assert property (read_result_low_op_i
    |=> acc_o == {$past(successive_result[1:0]), 2'h0})
    else $error("low read returned wrong value");
  a_high_read: assert property (read_result_high_op_i
    |=> {b_o, acc_o} == $past(successive_result[9:2]))
    else $error("high read returned wrong value");
  a_thr_locked: assert property ((load_threshold_op_i && !comp_mode)
    |=> $stable(comparator_threshold))
    else $error("threshold written outside comparator mode");
  a_dac_threshold: assert property (comp_mode && $stable(comp_mode)
    |=> dac_code_o == {$past(comparator_threshold), 2'h0})
    else $error("DAC not driven from threshold");
  a_irq_route: assert property ((int_accept_i && route_int && !done_set) |=> !irq_req_o)
    else $error("interrupt request stayed after acceptance");
endmodule
`default_nettype wire

// [core/sarc_pkg.sv]
package sarc_pkg;
  localparam int unsigned RES_W = 10;
  localparam int unsigned THR_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [9:0] RESULT_CLEAR = 10'h000;
  localparam logic [7:0] THR_RESET = 8'h00;
  localparam int unsigned MODE_BIT = 3;
  localparam int unsigned CLK_SRC_BIT = 2;
  localparam int unsigned PIN_PAIR_BIT = 2;
  localparam logic [2:0] SEL_MAX_VALID = 3'h3;
  localparam logic [1:0] MC_WAIT_LAST = 2'h1;
  localparam logic [3:0] SAR_TOP_BIT = 4'h9;
  localparam logic [3:0] SAR_LAST_BIT = 4'h0;
  localparam logic [5:0] DIV_BY_6 = 6'h06;
  localparam logic [5:0] DIV_BY_12 = 6'h0C;
  localparam logic [5:0] DIV_BY_24 = 6'h18;
  localparam logic [5:0] DIV_BY_48 = 6'h30;

  typedef enum logic [1:0] {SARC_IDLE, SARC_WAIT, SARC_SAR, SARC_CMP} sarc_state_e;

  function automatic logic [5:0] sarc_div_ratio(input logic [1:0] sel);
    logic [5:0] r;
    r = DIV_BY_6;
    case (sel)
      2'h0: r = DIV_BY_6;
      2'h1: r = DIV_BY_12;
      2'h2: r = DIV_BY_24;
      default: r = DIV_BY_48;
    endcase
    return r;
  endfunction
endpackage

// [core/sarc_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module sarc_sync (
  input wire logic core_clk_i, // core clock
  input wire logic rst_n_i,    // async reset, active low
  input wire logic async_i,    // level from outside the clock domain
  output logic sync_o          // synchronised level
);
  logic stage_one;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stage_one <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      stage_one <= async_i;
      sync_o <= stage_one;
    end
  end
endmodule
`default_nettype wire

// [core/sarc_clk_div.sv]
`timescale 1ns/100ps
`default_nettype none
module sarc_clk_div (
  input wire logic core_clk_i, // core clock
  input wire logic rst_n_i,    // async reset, active low
  input wire logic tick_i,     // one pulse per source clock period
  input wire logic [5:0] ratio_i, // division ratio
  input wire logic restart_i,  // realign the divided clock
  output logic converter_clock_tick_o     // one pulse per converter clock period
);
  logic [5:0] cnt;
  logic wrap;

  assign wrap = tick_i && (cnt == 6'(ratio_i - 6'h01));

  // restart gives a full first period so the sequence length is exact
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt <= 6'h00;
    else if (restart_i || wrap)
      cnt <= 6'h00;
    else if (tick_i)
      cnt <= 6'(cnt + 6'h01);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      converter_clock_tick_o <= 1'b0;
    else
      converter_clock_tick_o <= wrap && !restart_i;
  end
endmodule
`default_nettype wire

// [verification/sarc_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sarc_core_model (
  input wire logic core_clk_i,       // core clock
  input wire logic rst_n_i,          // async reset, active low
  input wire logic [9:0] dac_code_i, // DAC code from the block
  input wire logic [10:0] vin_i,     // analog input in DAC steps of 1/1024
  output logic instr_tick_o,         // one pulse per machine cycle
  output logic osc_clk_o,            // on-chip oscillator, free running
  output logic comp_above_o          // high while reference is below input
);
  logic [1:0] phase;

  // the oscillator runs free; 34 ns keeps it under a quarter of the core rate
  initial
  begin
    osc_clk_o = 1'b0;
    forever #17 osc_clk_o = ~osc_clk_o;
  end

  // a machine cycle every four core cycles, so both tick sources stay slow
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase <= 2'h0;
      instr_tick_o <= 1'b0;
    end
    else
    begin
      phase <= phase + 2'h1;
      instr_tick_o <= (phase == 2'h3);
    end
  end

  // ideal comparator: settles at once, so only the block's sync adds delay
  assign comp_above_o = ({1'b0, dac_code_i} < vin_i);
endmodule
`default_nettype wire

// [verification/sar_converter_comparator_ctrl_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module sar_converter_comparator_ctrl_tb;
  import sarc_pkg::*;
  localparam int WMD = 0, RMD = 1, WPN = 2, RPN = 3, WCK = 4, RCK = 5, STA = 6;
  localparam int RHI = 7, RLO = 8, LTH = 9, RTH = 10, SKP = 11, ACC = 12;
  logic core_clk, rst_n, route, tick, osc, comp, skip_seen;
  logic [12:0] op_vec;
  logic [3:0] acc, bb, acc_o, b_o, pin_en;
  logic [10:0] vin;
  logic skip_o, irq_o, flag_o, busy_o, sel_ok;
  logic [9:0] dac_o;
  logic [1:0] sel_o;
  logic [7:0] thr;
  int error_cnt = 0;
  int n_compared = 0;
  int ratio_tab[4] = '{6, 12, 24, 48};
  logic [9:0] exp_q[$];

  sarc_ctrl i_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .instr_tick_i(tick),
    .osc_clk_i(osc), .comp_above_i(comp), .acc_i(acc), .b_i(bb),
    .write_mode_select_op_i(op_vec[WMD]), .read_mode_select_op_i(op_vec[RMD]),
    .write_pin_func_op_i(op_vec[WPN]), .read_pin_func_op_i(op_vec[RPN]),
    .write_clk_sel_op_i(op_vec[WCK]), .read_clk_sel_op_i(op_vec[RCK]),
    .convert_start_op_i(op_vec[STA]), .read_result_high_op_i(op_vec[RHI]),
    .read_result_low_op_i(op_vec[RLO]), .load_threshold_op_i(op_vec[LTH]),
    .read_threshold_op_i(op_vec[RTH]), .done_flag_skip_test_i(op_vec[SKP]),
    .int_accept_i(op_vec[ACC]), .int_route_sel_i(route), .acc_o(acc_o), .b_o(b_o),
    .skip_o(skip_o), .irq_req_o(irq_o), .conversion_done_flag_o(flag_o),
    .busy_o(busy_o), .dac_code_o(dac_o), .analog_sel_o(sel_o),
    .analog_sel_valid_o(sel_ok), .analog_pin_en_o(pin_en));

  sarc_core_model i_core (.core_clk_i(core_clk), .rst_n_i(rst_n), .dac_code_i(dac_o),
    .vin_i(vin), .instr_tick_o(tick), .osc_clk_o(osc), .comp_above_o(comp));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // strobe for one cycle; registered answers are readable when this returns
  task automatic do_op(input int idx, input logic [3:0] a, input logic [3:0] b);
    @(posedge core_clk);
    op_vec <= 13'h0001 << idx;
    acc <= a;
    bb <= b;
    #1;
    skip_seen = skip_o;
    @(posedge core_clk);
    op_vec <= 13'h0000;
    #1;
  endtask

  function automatic logic [9:0] sar_model(input int v);
    int r;
    r = 0;
    for (int i = 9; i >= 0; i--)
      if ((r | (1 << i)) < v)
        r = r | (1 << i);
    return r[9:0];
  endfunction

  // start, then count machine ticks until idle; a second start mid-run must be ignored
  task automatic run_op(input int exp_ticks, input bit chk_ticks, input logic [9:0] exp_dac);
    int n;
    int guard;
    n = 0;
    guard = 0;
    do_op(STA, 4'h0, 4'h0);
    chk("busy", {9'h000, busy_o}, 10'h001);
    chk("start dac", dac_o, exp_dac);
    while (busy_o !== 1'b0 && guard < 4000)
    begin
      @(posedge core_clk);
      if (tick === 1'b1)
        n++;
      op_vec <= (guard == 20) ? 13'h0040 : 13'h0000;
      guard++;
      #1;
    end
    chk("done in time", {9'h000, busy_o}, 10'h000);
    if (chk_ticks)
      chk("ticks", n[9:0], exp_ticks[9:0]);
  endtask

  task automatic read_result(input logic [9:0] exp);
    do_op(RHI, 4'h0, 4'h0);
    chk("high", {2'h0, b_o, acc_o}, {2'h0, exp[9:2]});
    do_op(RLO, 4'hF, 4'h0);
    chk("low", {6'h00, acc_o}, {6'h00, exp[1:0], 2'h0});
  endtask

  initial
  begin
    logic [3:0] p;
    int v;
    rst_n = 1'b0;
    op_vec = 13'h0000;
    acc = 4'h0;
    bb = 4'h0;
    route = 1'b0;
    vin = 11'h000;
    void'($urandom(32'h31bdaaa7));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = RMD; i <= RCK; i += 2)
    begin
      do_op(i, 4'hF, 4'h0);
      chk("ctrl reset", {6'h00, acc_o}, {6'h00, CTRL_RESET});
    end
    p = 4'($urandom);
    do_op(WPN, p, 4'h0);
    @(posedge core_clk);
    #1;
    chk("pin enable", {6'h00, pin_en}, {6'h00, p[2], p[2], p[1], p[0]});
    do_op(RPN, 4'h0, 4'h0);
    chk("pin readback", {6'h00, acc_o}, {6'h00, p});
    for (int c = 7; c >= 0; c--)
    begin
      do_op(WMD, 4'(c), 4'h0);
      @(posedge core_clk);
      #1;
      chk("sel valid", {9'h000, sel_ok}, {9'h000, c <= 3});
      if (c <= 3)
        chk("sel", {8'h00, sel_o}, 10'(c));
      do_op(RMD, 4'h0, 4'h0);
      chk("mode readback", {6'h00, acc_o}, 10'(c));
    end
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 0 : (i == 3) ? 1024 : $urandom_range(1023, 1);
      @(posedge core_clk);
      vin <= 11'(v);
      route <= i[0];
      do_op(WCK, 4'(i), 4'h0);
      exp_q.push_back(sar_model(v));
      run_op(2 + 10 * ratio_tab[i], 1'b1, RESULT_CLEAR);
      chk("flag", {9'h000, flag_o}, 10'h001);
      chk("irq", {9'h000, irq_o}, {9'h000, i[0]});
      read_result(exp_q.pop_front());
      do_op(i[0] ? ACC : SKP, 4'h0, 4'h0);
      chk("skip", {9'h000, skip_seen}, {9'h000, !i[0]});
      chk("flag clear", {9'h000, flag_o}, 10'h000);
      do_op(SKP, 4'h0, 4'h0);
      chk("no skip", {9'h000, skip_seen}, 10'h000);
    end
    v = $urandom_range(1023, 1);
    @(posedge core_clk);
    vin <= 11'(v);
    route <= 1'b0;
    do_op(WCK, 4'h4, 4'h0);
    exp_q.push_back(sar_model(v));
    run_op(0, 1'b0, RESULT_CLEAR);
    read_result(exp_q.pop_front());
    do_op(SKP, 4'h0, 4'h0);
    do_op(WCK, 4'h0, 4'h0);
    do_op(LTH, 4'h5, 4'h5);
    do_op(WMD, 4'h8, 4'h0);
    thr = 8'($urandom_range(254, 1));
    do_op(LTH, thr[3:0], thr[7:4]);
    @(posedge core_clk);
    #1;
    chk("dac thr", dac_o, {thr, 2'h0});
    for (int k = 0; k < 2; k++)
    begin
      @(posedge core_clk);
      vin <= (k == 0) ? 11'({thr, 2'h0} - 3) : 11'({thr, 2'h0} + 3);
      run_op(2 + 6, 1'b1, {thr, 2'h0});
      chk("cmp flag", {9'h000, flag_o}, {9'h000, k == 0});
      do_op(SKP, 4'h0, 4'h0);
      chk("cmp skip", {9'h000, skip_seen}, {9'h000, k == 0});
    end
    do_op(WMD, 4'h0, 4'h0);
    do_op(SKP, 4'h0, 4'h0);
    do_op(LTH, 4'hA, 4'hA);
    do_op(WMD, 4'h8, 4'h0);
    do_op(RTH, 4'h0, 4'h0);
    chk("thr kept", {2'h0, b_o, acc_o}, {2'h0, thr});
    end_of_test();
  end

  initial
  begin
    #100000;
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
